/* File: include/e1fie_consts.svh */
// register offsets, field positions, reset values of the framer event block
// assumes: included by bare name wherever constants are needed
`ifndef E1FIE_CONSTS_SVH
`define E1FIE_CONSTS_SVH
`define E1FIE_FLAGS_OFF 12'h004
`define E1FIE_ENABLES_OFF 12'h008
`define E1FIE_SIGCHG_OFF 12'h00C
`define E1FIE_CTRL_OFF 12'h010
`define E1FIE_RAW_OFF 12'h014
`define E1FIE_BIT_FE 0
`define E1FIE_BIT_CRC 1
`define E1FIE_BIT_FMD 2
`define E1FIE_BIT_OOF 3
`define E1FIE_BIT_COFA 4
`define E1FIE_BIT_SIG 5
`define E1FIE_BIT_NBIT 6
`define E1FIE_BIT_COMFA 7
`define E1FIE_RST8 8'h00
`define E1FIE_RST32 32'h0000_0000
`define E1FIE_NCHAN 30
`endif

/* File: include/e1fie_pkg.sv */
// types of the framer event block
// assumes: compiled before all design files
package e1fie_pkg;
  typedef logic [7:0] e1fie_byte_t;
  typedef logic [11:0] e1fie_addr_t;
endpackage : e1fie_pkg

/* File: include/e1fie_evt_if.sv */
// event bundle between top and the sticky flag bank
// assumes: one clock, set and clr driven by the top, q by the sticky flag bank
`timescale 1ns/1ps
interface e1fie_evt_if #(parameter int W = 8);
  logic [W-1:0] set;
  logic [W-1:0] clr;
  logic [W-1:0] q;
  modport ctl (output set, output clr, input q);
  modport bank (input set, input clr, output q);
endinterface : e1fie_evt_if

/* File: hw/e1fie_sticky.sv */
// sticky flag bank, set wins over clear
// assumes: single clock, async active low reset
`timescale 1ns/1ps
module e1fie_sticky #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic rst_b,
  e1fie_evt_if.bank evt
);
  logic [W-1:0] q_r;
  logic [W-1:0] q_nxt;
  assign q_nxt = (q_r & ~evt.clr) | evt.set;
  assign evt.q = q_r;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end
endmodule : e1fie_sticky

/* File: hw/e1fie_top.sv */
// framer event flags, enables and interrupt behind an APB slave
// assumes: event inputs are one-cycle pulses synchronous to clk
//
// Operation
// - crc-4 mismatch sets flag bit 1
// - alignment bit error sets flag bit 0
// - framing flag never drops sync state
// - reading flags register clears them
// - flag one means event since read
// - interrupt only when enable set
// - multiframe loss declared or cleared interrupts
// - any national bit change interrupts
// - any signaling bit change interrupts
// - per-channel signaling change record kept
// - signaling changes ignored while cas off
// - new alignment position interrupts
// - enables read-write, reset to zero
`timescale 1ns/1ps
`include "e1fie_consts.svh"
module e1fie_top
  import e1fie_pkg::*;
#(
  parameter int NCHAN = `E1FIE_NCHAN
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic crc_err_evt,
  input wire logic fas_err_evt,
  input wire logic fmd_evt,
  input wire logic oof_chg_evt,
  input wire logic cofa_evt,
  input wire logic mf_loss_lvl,
  input wire logic [4:0] nat_bits,
  input wire logic [NCHAN-1:0] sig_chg_evt,
  input wire logic cas_enabled,
  output logic irq,
  output logic framer_sync_lost
);
  // ****************************************
  // apb decode
  // ****************************************
  logic acc;
  logic wr;
  logic rd;
  logic hit_flags;
  logic hit_en;
  logic hit_sig;
  logic hit_ctrl;
  logic hit_raw;
  logic hit_any;
  assign acc = psel & penable & pready;
  assign wr = acc & pwrite;
  assign rd = acc & ~pwrite;
  assign hit_flags = (paddr == `E1FIE_FLAGS_OFF);
  assign hit_en = (paddr == `E1FIE_ENABLES_OFF);
  assign hit_sig = (paddr == `E1FIE_SIGCHG_OFF);
  assign hit_ctrl = (paddr == `E1FIE_CTRL_OFF);
  assign hit_raw = (paddr == `E1FIE_RAW_OFF);
  assign hit_any = hit_flags | hit_en | hit_sig | hit_ctrl | hit_raw;

  // ****************************************
  // registers
  // ****************************************
  e1fie_byte_t enables_r;
  logic sync_hold_r;
  logic mf_prev_r;
  logic [4:0] nat_prev_r;
  logic [NCHAN-1:0] sig_rec_r;
  logic [NCHAN-1:0] sig_rec_nxt;
  logic [31:0] rdata_nxt;
  logic ready_r;
  logic irq_nxt;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      enables_r <= `E1FIE_RST8;
      sync_hold_r <= 1'b0;
    end else if (wr && hit_en) begin
      enables_r <= pwdata[7:0];
    end else if (wr && hit_ctrl) begin
      sync_hold_r <= pwdata[0];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mf_prev_r <= 1'b0;
      nat_prev_r <= 5'h00;
    end else begin
      mf_prev_r <= mf_loss_lvl;
      nat_prev_r <= nat_bits;
    end
  end

  // ****************************************
  // event sources
  // ****************************************
  e1fie_evt_if #(.W(8)) evt ();
  logic mf_chg;
  logic nat_chg;
  logic sig_any;
  assign mf_chg = mf_loss_lvl ^ mf_prev_r;
  assign nat_chg = |(nat_bits ^ nat_prev_r);
  assign sig_any = cas_enabled & (|sig_chg_evt);
  assign evt.set[`E1FIE_BIT_CRC] = crc_err_evt;
  assign evt.set[`E1FIE_BIT_FE] = fas_err_evt;
  assign evt.set[`E1FIE_BIT_FMD] = fmd_evt;
  assign evt.set[`E1FIE_BIT_OOF] = oof_chg_evt;
  assign evt.set[`E1FIE_BIT_COFA] = cofa_evt;
  assign evt.set[`E1FIE_BIT_SIG] = sig_any;
  assign evt.set[`E1FIE_BIT_NBIT] = nat_chg;
  assign evt.set[`E1FIE_BIT_COMFA] = mf_chg;
  assign evt.clr = (rd && hit_flags) ? 8'hFF : 8'h00;

  e1fie_sticky #(.W(8)) u_flags (
    .clk(clk),
    .rst_b(rst_b),
    .evt(evt)
  );

  // ****************************************
  // signaling channel record
  // ****************************************
  // per-channel record, read clears
  assign sig_rec_nxt = ((rd && hit_sig) ? '0 : sig_rec_r)
                     | (cas_enabled ? sig_chg_evt : '0);
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sig_rec_r <= '0;
    end else begin
      sig_rec_r <= sig_rec_nxt;
    end
  end

  // ****************************************
  // read data and interrupt
  // ****************************************
  assign rdata_nxt = hit_flags ? {24'h000000, evt.q} :
                     hit_en ? {24'h000000, enables_r} :
                     hit_sig ? {{(32-NCHAN){1'b0}}, sig_rec_r} :
                     hit_ctrl ? {31'h00000000, sync_hold_r} :
                     hit_raw ? {26'h0000000, mf_loss_lvl, nat_bits} : `E1FIE_RST32;
  assign irq_nxt = |(evt.q & enables_r);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ready_r <= 1'b0;
      prdata <= `E1FIE_RST32;
      pslverr <= 1'b0;
      irq <= 1'b0;
      framer_sync_lost <= 1'b0;
    end else begin
      ready_r <= psel & ~penable;
      if (psel && !penable) begin
        prdata <= pwrite ? `E1FIE_RST32 : rdata_nxt;
        pslverr <= ~hit_any;
      end
      irq <= irq_nxt;
      framer_sync_lost <= sync_hold_r | (framer_sync_lost ^ oof_chg_evt);
    end
  end
  assign pready = ready_r;
endmodule : e1fie_top

/* File: verif/e1fie_props.sv */
// checker of the framer event block at its ports
// assumes: bound into e1fie_top, one clock
`timescale 1ns/1ps
`include "e1fie_consts.svh"
module e1fie_props (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic crc_err_evt,
  input wire logic fas_err_evt,
  input wire logic oof_chg_evt,
  input wire logic mf_loss_lvl,
  input wire logic [4:0] nat_bits,
  input wire logic irq,
  input wire logic framer_sync_lost
);
  logic [7:0] en_r;
  wire acc = psel && penable && pready;
  wire en_wr = acc && pwrite && paddr == `E1FIE_ENABLES_OFF;
  wire no_ev = !crc_err_evt && !fas_err_evt;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) en_r <= 8'h00;
    else if (en_wr) en_r <= pwdata[7:0];
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence en_rd_s;
    psel && !penable && !pwrite && paddr == `E1FIE_ENABLES_OFF;
  endsequence
  sequence clr_s;
    no_ev ##1 acc && !pwrite && paddr == `E1FIE_FLAGS_OFF && no_ev ##1 no_ev;
  endsequence
  en_read_a: assert property (en_rd_s |=> prdata == {24'h0, $past(en_r)})
    else $error("enable readback wrong");
  crc_irq_a: assert property (crc_err_evt && en_r[1] |-> ##2 irq)
    else $error("crc event without irq");
  fas_irq_a: assert property (fas_err_evt && en_r[0] |-> ##2 irq)
    else $error("fas event without irq");
  mf_irq_a: assert property ($changed(mf_loss_lvl) && en_r[7] |-> ##[1:3] irq)
    else $error("multiframe change without irq");
  nat_irq_a: assert property ($changed(nat_bits) && en_r[6] |-> ##[1:3] irq)
    else $error("national bit change without irq");
  mask_irq_a: assert property ($past(en_r) == 8'h00 |-> !irq)
    else $error("irq with all enables clear");
  sync_hold_a: assert property (fas_err_evt && !oof_chg_evt && !psel |=> $stable(framer_sync_lost))
    else $error("fas error moved sync state");
  rd_clear_a: assert property (clr_s ##0 en_r[7:2] == 6'h00 |=> !irq)
    else $error("irq held after flag read");
endmodule : e1fie_props
bind e1fie_top e1fie_props i_e1fie_props (.clk(clk), .rst_b(rst_b), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .crc_err_evt(crc_err_evt), .fas_err_evt(fas_err_evt),
  .oof_chg_evt(oof_chg_evt), .mf_loss_lvl(mf_loss_lvl), .nat_bits(nat_bits), .irq(irq),
  .framer_sync_lost(framer_sync_lost));

/* File: verif/tb.sv */
// self-checking bench of the framer event block
// assumes: apb slave top, checker bound to it
`timescale 1ns/1ps
`include "e1fie_consts.svh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) mism(g, e); end
module tb;
  logic clk = 1'h0, rst_b = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, irq, framer_sync_lost, crc_err_evt = 1'h0, fas_err_evt = 1'h0;
  logic cofa_evt = 1'h0, mf_loss_lvl = 1'h0, cas_enabled = 1'h1;
  logic [4:0] nat_bits = 5'h00;
  logic [29:0] sig_chg_evt = 30'h0;
  logic [16:0] rnd = 17'h17BA6;
  logic [32:0] q[$], exp_v;
  int err_total = 0, samples_checked = 0, ch = 0;
  int bits[6] = '{0, 1, 4, 5, 6, 7};
  always #2.5 clk = ~clk;
  e1fie_top i_e1fie_top (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .crc_err_evt(crc_err_evt), .fas_err_evt(fas_err_evt), .fmd_evt(1'h0),
    .oof_chg_evt(1'h0), .cofa_evt(cofa_evt), .mf_loss_lvl(mf_loss_lvl), .nat_bits(nat_bits),
    .sig_chg_evt(sig_chg_evt), .cas_enabled(cas_enabled), .irq(irq),
    .framer_sync_lost(framer_sync_lost));
  function automatic logic [16:0] lfsr(input logic [16:0] s);
    return {s[15:0], s[16] ^ s[13]};
  endfunction : lfsr
  task automatic mism(input logic [32:0] g, input logic [32:0] e);
    err_total++;
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
  endtask : mism
  task automatic test_done;
    $display("errors=%0d checks=%0d", err_total, samples_checked);
    if (err_total == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : test_done
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
    input logic [32:0] e);
    int n = 0;
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    if (!w) q.push_back(e);
    @(posedge clk);
    penable <= 1'h1;
    @(posedge clk);
    while (!pready && n < 20) begin
      @(posedge clk);
      n++;
    end
    if (!pready) err_total++;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  task automatic fire(input int b);
    @(posedge clk);
    rnd = lfsr(rnd);
    ch = int'(rnd % 30);
    case (b)
      0: fas_err_evt <= 1'h1;
      1: crc_err_evt <= 1'h1;
      4: cofa_evt <= 1'h1;
      5: sig_chg_evt <= 30'h1 << ch;
      6: nat_bits <= nat_bits ^ (rnd[4:0] | 5'h01);
      default: mf_loss_lvl <= !mf_loss_lvl;
    endcase
    @(posedge clk);
    {fas_err_evt, crc_err_evt, cofa_evt} <= 3'h0;
    sig_chg_evt <= 30'h0;
    repeat (3) @(posedge clk);
  endtask : fire
  always @(posedge clk) begin
    if (psel && penable && pready && !pwrite) begin
      exp_v = q.pop_front();
      `CHK({pslverr, prdata}, exp_v)
    end
  end
  initial begin
    repeat (4000) @(posedge clk);
    err_total++;
    test_done();
  end
  initial begin
    repeat (16) @(posedge clk);
    rst_b <= 1'h1;
    apb(0, `E1FIE_ENABLES_OFF, 0, 33'h0);
    apb(0, `E1FIE_FLAGS_OFF, 0, 33'h0);
    apb(0, 12'h0FC, 0, 33'h1_0000_0000);
    foreach (bits[i]) begin
      apb(1, `E1FIE_ENABLES_OFF, 32'h1 << bits[i], 0);
      apb(0, `E1FIE_ENABLES_OFF, 0, 33'h1 << bits[i]);
      fire(bits[i]);
      `CHK(irq, 1'h1)
      if (bits[i] == 5) apb(0, `E1FIE_SIGCHG_OFF, 0, 33'h1 << ch);
      apb(0, `E1FIE_FLAGS_OFF, 0, 33'h1 << bits[i]);
      repeat (2) @(posedge clk);
      `CHK(irq, 1'h0)
      apb(0, `E1FIE_FLAGS_OFF, 0, 33'h0);
    end
    apb(1, `E1FIE_ENABLES_OFF, 32'h20, 0);
    cas_enabled <= 1'h0;
    fire(5);
    fire(1);
    `CHK(irq, 1'h0)
    apb(0, `E1FIE_FLAGS_OFF, 0, 33'h2);
    `CHK(framer_sync_lost, 1'h0)
    test_done();
  end
endmodule : tb
